// *** rtl/nfhc_defines.vh ***
// constants for the nand program/erase host sequencer
`ifndef NFHC_DEFINES_VH
`define NFHC_DEFINES_VH
`define NFHC_CMD_READ0 8'h00
`define NFHC_CMD_PROG_IN 8'h80
`define NFHC_CMD_PROG_IN2 8'h81
`define NFHC_CMD_COL_CHG 8'h85
`define NFHC_CMD_PROG_GO 8'h10
`define NFHC_CMD_PROG_MID 8'h11
`define NFHC_CMD_CB_READ 8'h35
`define NFHC_CMD_ERASE 8'h60
`define NFHC_CMD_ERASE_GO 8'hd0
`define NFHC_CMD_STAT 8'h70
`define NFHC_CMD_STAT2 8'h71
`define NFHC_CMD_RESET 8'hff
`define NFHC_OP_PROG 3'h0
`define NFHC_OP_MPROG 3'h1
`define NFHC_OP_ERASE 3'h2
`define NFHC_OP_MERASE 3'h3
`define NFHC_OP_CBREAD 3'h4
`define NFHC_OP_CBPROG 3'h5
`define NFHC_OP_STATUS 3'h6
`define NFHC_OP_RESET 3'h7
`define NFHC_MAIN_BYTES 12'h200
`define NFHC_SPARE_BASE 12'h800
`define NFHC_SPARE_BYTES 12'h010
`define NFHC_PARITY_BASE 12'h840
`define NFHC_STROBE_CYC 4'h3
`endif

// *** rtl/nfhc_host.v ***
// host sequencer driving a two-district nand for program, erase, copy-back
// What this block does
// - sector main and spare written together, except the second district of a multi program, which gets no 85h
// - data command, address, data, then confirm
// - only status or reset between 11 and 81
// - one block per district, same page
// - multi program finished by confirm unless the busy wait after 11h times out
// - erase uses 60h, block address, d0h
// - multi erase ends with d0h; it never issues reset
// - copy-back program 85h, address, data, 10h
// - copy-back source and target share district
// - latches marked by cle, ale, chip select
// - five address cycles, column then row
`timescale 1ns/1ps
`include "nfhc_defines.vh"
module nfhc_host #(
   parameter BUSY_WAIT_MAX = 32'd5000000
) (
   input wire mclk,
   input wire rst,
   input wire cmd_valid,
   input wire [2:0] cmd_op,
   input wire [16:0] cmd_row_a,
   input wire [16:0] cmd_row_b,
   input wire [11:0] cmd_col,
   input wire [11:0] cmd_len,
   input wire [11:0] cmd_col2,
   input wire [11:0] cmd_len2,
   input wire wr_protect_off,
   output reg cmd_ready,
   output reg cmd_done,
   output reg cmd_error,
   output reg [7:0] status_q,
   input wire wdata_valid,
   input wire [7:0] wdata,
   output reg wdata_ready,
   output reg nand_ce_n,
   output reg nand_cle,
   output reg nand_ale,
   output reg nand_we_n,
   output reg read_strobe_low,
   output reg nand_wp_n,
   output reg [7:0] nand_io_out,
   output reg nand_io_oe,
   input wire [7:0] nand_io_in,
   input wire ready_busy_out
);
////////////////////////////////////////////////////////////////////////////
localparam S_IDLE = 4'h0;
localparam S_CMD = 4'h1;
localparam S_ADDR = 4'h2;
localparam S_DATA = 4'h3;
localparam S_WAIT = 4'h4;
localparam S_STAT = 4'h5;
localparam S_DONE = 4'h6;
localparam S_NEXT = 4'h7;
reg [3:0] st_q;
reg [3:0] ph_q;
reg [2:0] op_q;
reg [3:0] step_q;
reg [2:0] acnt_q;
reg [2:0] alen_q;
reg [11:0] bcnt_q;
reg [7:0] obyte_q;
reg [1:0] strb_q;
reg [3:0] tcnt_q;
reg [31:0] bwait_q;
reg [16:0] row_a_q, row_b_q;
reg [11:0] col_q, len_q, col2_q, len2_q;
reg bad_q;
// two-entry skid buffer between user data and the bus
reg [7:0] buf_d0_q, buf_d1_q;
reg [1:0] buf_n_q;
wire buf_take = (st_q == S_DATA) && (ph_q == 4'h0) && (buf_n_q != 2'h0);
wire buf_push = wdata_valid && wdata_ready;
wire [11:0] col_end = col_q + len_q;
wire [11:0] col2_end = col2_q + len2_q;
wire multi = (op_q == `NFHC_OP_MPROG) || (op_q == `NFHC_OP_MERASE);
// first data run reaching the parity area is refused up front; sector crossing is not checked
wire sect_ok = (len_q == 12'h000) ||
   (col_end <= `NFHC_PARITY_BASE);
wire dist_ok = !multi || (row_a_q[6] != row_b_q[6]);
wire page_ok = !multi || (op_q == `NFHC_OP_MERASE) ||
   (row_a_q[5:0] == row_b_q[5:0]);
wire cb_ok = (op_q != `NFHC_OP_CBPROG) ||
   (row_a_q[6] == row_b_q[6]);
////////////////////////////////////////////////////////////////////////////
// sequence table: for each op and step, the command byte and what follows
// follow: 0 status read, 1 full address, 2 column only, 3 row only, 5 busy
reg [7:0] seq_cmd;
reg [2:0] seq_fol;
reg seq_last;
always @* begin
   seq_cmd = `NFHC_CMD_STAT;
   seq_fol = 3'h0;
   seq_last = 1'b1;
   case (op_q)
      `NFHC_OP_PROG, `NFHC_OP_MPROG, `NFHC_OP_CBPROG: begin
         case (step_q)
            4'h0: begin
               seq_cmd = (op_q == `NFHC_OP_CBPROG) ? `NFHC_CMD_COL_CHG :
                  `NFHC_CMD_PROG_IN;
               seq_fol = 3'h1;
               seq_last = 1'b0;
            end
            4'h1: begin
               seq_cmd = `NFHC_CMD_COL_CHG;
               seq_fol = 3'h2;
               seq_last = 1'b0;
            end
            4'h2: begin
               seq_cmd = (op_q == `NFHC_OP_MPROG) ? `NFHC_CMD_PROG_MID :
                  `NFHC_CMD_PROG_GO;
               seq_fol = 3'h5;
               seq_last = (op_q != `NFHC_OP_MPROG);
            end
            4'h3: begin
               seq_cmd = `NFHC_CMD_PROG_IN2;
               seq_fol = 3'h1;
               seq_last = 1'b0;
            end
            default: begin
               seq_cmd = `NFHC_CMD_PROG_GO;
               seq_fol = 3'h5;
            end
         endcase
      end
      `NFHC_OP_ERASE, `NFHC_OP_MERASE: begin
         case (step_q)
            4'h0: begin
               seq_cmd = `NFHC_CMD_ERASE;
               seq_fol = 3'h3;
               seq_last = 1'b0;
            end
            4'h1: begin
               seq_cmd = (op_q == `NFHC_OP_MERASE) ? `NFHC_CMD_ERASE :
                  `NFHC_CMD_ERASE_GO;
               seq_fol = (op_q == `NFHC_OP_MERASE) ? 3'h3 : 3'h5;
               seq_last = (op_q != `NFHC_OP_MERASE);
            end
            default: begin
               seq_cmd = `NFHC_CMD_ERASE_GO;
               seq_fol = 3'h5;
            end
         endcase
      end
      `NFHC_OP_CBREAD: begin
         seq_cmd = (step_q == 4'h0) ? `NFHC_CMD_READ0 : `NFHC_CMD_CB_READ;
         seq_fol = (step_q == 4'h0) ? 3'h1 : 3'h5;
         seq_last = (step_q != 4'h0);
      end
      `NFHC_OP_RESET: begin
         seq_cmd = `NFHC_CMD_RESET;
         seq_fol = 3'h5;
      end
      default: begin
         seq_cmd = `NFHC_CMD_STAT2;
      end
   endcase
end
////////////////////////////////////////////////////////////////////////////
// address byte for acnt_q; second group uses row b
wire [16:0] cur_row = ((step_q == 4'h3) || (step_q == 4'h1 &&
   op_q == `NFHC_OP_MERASE)) ? row_b_q :
   (op_q == `NFHC_OP_CBPROG ? row_b_q : row_a_q);
wire [11:0] cur_col = (step_q == 4'h1) ? col2_q : col_q;
reg [7:0] abyte;
always @* begin
   abyte = 8'h00;
   case (acnt_q)
      3'h0: abyte = cur_col[7:0];
      3'h1: abyte = {4'h0, cur_col[11:8]};
      3'h2: abyte = cur_row[7:0];
      3'h3: abyte = cur_row[15:8];
      default: abyte = {7'h00, cur_row[16]};
   endcase
end
// row-only cycles start at index 2
wire [2:0] a_first = (seq_fol == 3'h3) ? 3'h2 : 3'h0;
wire [2:0] a_stop = (seq_fol == 3'h2) ? 3'h2 : 3'h5;
wire [11:0] data_n = (step_q == 4'h1) ? len2_q : len_q;
// only program-type ops have an optional 85h step; erase step 1 is real
wire skip_chg = (step_q == 4'h1) && (len2_q == 12'h000) &&
   (op_q == `NFHC_OP_PROG || op_q == `NFHC_OP_MPROG ||
   op_q == `NFHC_OP_CBPROG);
////////////////////////////////////////////////////////////////////////////
always @(posedge mclk or posedge rst) begin
   if (rst) begin
      st_q <= S_IDLE;
      ph_q <= 4'h0;
      op_q <= 3'h0;
      step_q <= 4'h0;
      acnt_q <= 3'h0;
      alen_q <= 3'h0;
      bcnt_q <= 12'h000;
      obyte_q <= 8'h00;
      strb_q <= 2'h0;
      tcnt_q <= 4'h0;
      bwait_q <= 32'h00000000;
      row_a_q <= 17'h00000;
      row_b_q <= 17'h00000;
      col_q <= 12'h000;
      len_q <= 12'h000;
      col2_q <= 12'h000;
      len2_q <= 12'h000;
      bad_q <= 1'b0;
      buf_d0_q <= 8'h00;
      buf_d1_q <= 8'h00;
      buf_n_q <= 2'h0;
      cmd_ready <= 1'b0;
      cmd_done <= 1'b0;
      cmd_error <= 1'b0;
      status_q <= 8'h00;
      wdata_ready <= 1'b0;
      nand_ce_n <= 1'b1;
      nand_cle <= 1'b0;
      nand_ale <= 1'b0;
      nand_we_n <= 1'b1;
      read_strobe_low <= 1'b1;
      nand_wp_n <= 1'b0;
      nand_io_out <= 8'h00;
      nand_io_oe <= 1'b0;
   end else begin
      cmd_done <= 1'b0;
      cmd_error <= 1'b0;
      nand_wp_n <= wr_protect_off;
      // buffer: pop when the bus takes a byte, push from the user
      case ({buf_push, buf_take})
         2'b10: begin
            if (buf_n_q == 2'h0) buf_d0_q <= wdata;
            else buf_d1_q <= wdata;
            buf_n_q <= buf_n_q + 2'h1;
         end
         2'b01: begin
            buf_d0_q <= buf_d1_q;
            buf_n_q <= buf_n_q - 2'h1;
         end
         2'b11: begin
            if (buf_n_q == 2'h1) buf_d0_q <= wdata;
            else begin
               buf_d0_q <= buf_d1_q;
               buf_d1_q <= wdata;
            end
         end
         default: begin
         end
      endcase
      wdata_ready <= (st_q == S_DATA) && ((buf_n_q + {1'b0, buf_push})
         < 2'h2 + {1'b0, buf_take});
      case (st_q)
         S_IDLE: begin
            cmd_ready <= 1'b1;
            nand_ce_n <= 1'b1;
            if (cmd_valid && cmd_ready) begin
               cmd_ready <= 1'b0;
               op_q <= cmd_op;
               row_a_q <= cmd_row_a;
               row_b_q <= cmd_row_b;
               col_q <= cmd_col;
               len_q <= cmd_len;
               col2_q <= cmd_col2;
               len2_q <= cmd_len2;
               step_q <= 4'h0;
               st_q <= S_NEXT;
            end
         end
         S_NEXT: begin
            bad_q <= !(sect_ok && dist_ok && page_ok && cb_ok);
            st_q <= (sect_ok && dist_ok && page_ok && cb_ok) ? S_CMD :
               S_DONE;
            nand_ce_n <= !(sect_ok && dist_ok && page_ok && cb_ok);
            ph_q <= 4'h0;
         end
         S_CMD: begin
            // one write strobe: setup, we low, we high, hold
            nand_cle <= 1'b1;
            nand_io_oe <= 1'b1;
            nand_io_out <= seq_cmd;
            ph_q <= ph_q + 4'h1;
            nand_we_n <= !(ph_q == 4'h1);
            if (skip_chg) begin
               step_q <= step_q + 4'h1;
               nand_cle <= 1'b0;
               ph_q <= 4'h0;
            end else if (ph_q == `NFHC_STROBE_CYC) begin
               nand_cle <= 1'b0;
               ph_q <= 4'h0;
               acnt_q <= a_first;
               alen_q <= a_stop;
               bcnt_q <= 12'h000;
               bwait_q <= 32'h00000000;
               case (seq_fol)
                  3'h0: st_q <= S_STAT;
                  3'h5: st_q <= S_WAIT;
                  default: st_q <= S_ADDR;
               endcase
            end
         end
         S_ADDR: begin
            nand_ale <= 1'b1;
            nand_io_out <= abyte;
            ph_q <= ph_q + 4'h1;
            nand_we_n <= !(ph_q == 4'h1);
            if (ph_q == `NFHC_STROBE_CYC) begin
               ph_q <= 4'h0;
               acnt_q <= acnt_q + 3'h1;
               if (acnt_q + 3'h1 == alen_q) begin
                  nand_ale <= 1'b0;
                  if (seq_fol == 3'h3 || op_q == `NFHC_OP_CBREAD ||
                     data_n == 12'h000) begin
                     step_q <= step_q + 4'h1;
                     st_q <= S_CMD;
                  end else
                     st_q <= S_DATA;
               end
            end
         end
         S_DATA: begin
            if (ph_q == 4'h0) begin
               if (buf_n_q != 2'h0) begin
                  nand_io_out <= buf_d0_q;
                  ph_q <= 4'h1;
               end
            end else begin
               ph_q <= ph_q + 4'h1;
               nand_we_n <= !(ph_q == 4'h1);
               if (ph_q == `NFHC_STROBE_CYC) begin
                  ph_q <= 4'h0;
                  bcnt_q <= bcnt_q + 12'h001;
                  if (bcnt_q + 12'h001 == data_n) begin
                     step_q <= step_q + 4'h1;
                     st_q <= S_CMD;
                  end
               end
            end
         end
         S_WAIT: begin
            // device pulls ready/busy low after confirm; give it time
            bwait_q <= bwait_q + 32'h00000001;
            if (bwait_q > {28'h0000000, `NFHC_STROBE_CYC} &&
               ready_busy_out) begin
               if (seq_last) begin
                  op_q <= (op_q == `NFHC_OP_RESET ||
                     op_q == `NFHC_OP_CBREAD) ? op_q : `NFHC_OP_STATUS;
                  st_q <= (op_q == `NFHC_OP_RESET ||
                     op_q == `NFHC_OP_CBREAD) ? S_DONE : S_CMD;
               end else begin
                  step_q <= step_q + 4'h1;
                  st_q <= S_CMD;
               end
            end else if (bwait_q == BUSY_WAIT_MAX) begin
               bad_q <= 1'b1;
               st_q <= S_DONE;
            end
         end
         S_STAT: begin
            // status_q keeps the byte read after 71h until the next status read, past reset, copy-back read and refused commands
            nand_io_oe <= 1'b0;
            ph_q <= ph_q + 4'h1;
            read_strobe_low <= !(ph_q == 4'h1 || ph_q == 4'h2);
            if (ph_q == `NFHC_STROBE_CYC) begin
               status_q <= nand_io_in;
               bad_q <= nand_io_in[0] | nand_io_in[1] |
                  nand_io_in[2];
               st_q <= S_DONE;
            end
         end
         default: begin
            nand_ce_n <= 1'b1;
            nand_io_oe <= 1'b0;
            read_strobe_low <= 1'b1;
            nand_we_n <= 1'b1;
            cmd_done <= 1'b1;
            cmd_error <= bad_q;
            bad_q <= 1'b0;
            st_q <= S_IDLE;
         end
      endcase
   end
end
endmodule // nfhc_host

// *** test/nfhc_dev_model.sv ***
// behavioural two-district nand device facing the host sequencer
`timescale 1ns/1ps
module nfhc_dev_model #(
   parameter BUSY_NS = 4000
) (
   input wire nand_ce_n,
   input wire nand_cle,
   input wire nand_ale,
   input wire nand_we_n,
   input wire read_strobe_low,
   input wire nand_wp_n,
   input wire [7:0] nand_io_out,
   input wire fail0,
   input wire fail1,
   output wire [7:0] nand_io_in,
   output reg ready_busy_out
);
reg [7:0] mem [0:2175];
reg [2:0] stat;
reg [11:0] col;
reg [16:0] row;
reg [5:0] pg;
reg [1:0] dm, cb;
reg mult, sd, rowok, a11;
integer na, n_bad, n_cmd;
event go;
initial begin
   ready_busy_out = 1'b1;
   {stat, dm, cb, mult, a11, rowok} = 11'h000;
   na = 0;
   n_bad = 0;
   n_cmd = 0;
end
// released bus shows the inverse byte, never the last one
assign nand_io_in = (!nand_ce_n && !read_strobe_low) ? {nand_wp_n,
   {2{ready_busy_out}}, 2'b00, stat} : ~nand_io_out;
// busy length varies so the host sees prompt and slow answers
always @(go) begin
   ready_busy_out = 1'b0;
   #(BUSY_NS + 300 * (n_cmd % 4));
   ready_busy_out = 1'b1;
end
always @(posedge nand_we_n) if (!nand_ce_n) begin
   if (nand_cle) begin
      n_cmd = n_cmd + 1;
      if (a11 && !(nand_io_out inside {8'h81, 8'h70, 8'h71, 8'hff}))
         n_bad = n_bad + 1;
      a11 = nand_io_out == 8'h11 || (a11 && nand_io_out[7:1] == 7'h38);
      case (nand_io_out)
         8'h80, 8'h00: begin
            {na, rowok, dm, mult} = 0;
         end
         8'h81: begin
            {na, rowok} = 0;
            mult = 1'b1;
         end
         8'h85: begin
            na = 0;
            if (cb == 2'h1) {rowok, cb} = 3'h2;
         end
         8'h60: begin
            na = 2;
            rowok = 1'b0;
         end
         8'h11: if (!rowok) n_bad = n_bad + 1;
         8'h35: begin
            if (!rowok) n_bad = n_bad + 1;
            {cb, sd, dm} = {2'h1, row[6], 2'h0};
            -> go;
         end
         8'h10, 8'hd0: begin
            if (!rowok) n_bad = n_bad + 1;
            if (nand_wp_n) -> go;
            stat = nand_wp_n ? {dm[1] & fail1, dm[0] & fail0,
               |(dm & {fail1, fail0})} : 3'h0;
            {dm, cb, mult} = 5'h00;
         end
         8'hff: {stat, dm, cb, a11} = 8'h00;
         default: ;
      endcase
   end else if (nand_ale) begin
      case (na)
         0: col[7:0] = nand_io_out;
         1: col[11:8] = nand_io_out[3:0];
         2: row[7:0] = nand_io_out;
         3: row[15:8] = nand_io_out;
         default: begin
            row[16] = nand_io_out[0];
            if ((mult && row[5:0] !== pg) || dm[row[6]]) n_bad = n_bad + 1;
            if (cb != 2'h0 && row[6] !== sd) n_bad = n_bad + 1;
            pg = row[5:0];
            dm[row[6]] = 1'b1;
            rowok = 1'b1;
         end
      endcase
      na = na + 1;
   end else begin
      if (col > 12'd2111) n_bad = n_bad + 1;
      else mem[col] = nand_io_out;
      col = col + 12'h001;
   end
end
endmodule // nfhc_dev_model

// *** test/nfhc_host_asserts.sv ***
// concurrent checks on the host sequencer pins and handshake
`timescale 1ns/1ps
module nfhc_host_asserts (
   input wire mclk,
   input wire rst,
   input wire cmd_done,
   input wire cmd_error,
   input wire wr_protect_off,
   input wire nand_ce_n,
   input wire nand_cle,
   input wire nand_ale,
   input wire nand_we_n,
   input wire read_strobe_low,
   input wire nand_wp_n,
   input wire [7:0] nand_io_out,
   input wire nand_io_oe,
   input wire ready_busy_out
);
default clocking dc @(posedge mclk);
endclocking
default disable iff (rst);
property p_latch_kind;
   !nand_we_n |-> !nand_ce_n && !(nand_cle && nand_ale) && read_strobe_low;
endproperty
a_latch_kind: assert property (p_latch_kind) else $error("strobe mix");
property p_we_one;
   $fell(nand_we_n) |=> $rose(nand_we_n);
endproperty
a_we_one: assert property (p_we_one) else $error("write strobe width");
property p_io_held;
   $rose(nand_we_n) |-> nand_io_oe && $stable(nand_io_out);
endproperty
a_io_held: assert property (p_io_held) else $error("byte moved");
property p_read_quiet;
   !read_strobe_low |-> !nand_io_oe && nand_we_n;
endproperty
a_read_quiet: assert property (p_read_quiet) else $error("bus fight");
property p_wp;
   !$stable(wr_protect_off) |-> ##[1:2] nand_wp_n == wr_protect_off;
endproperty
a_wp: assert property (p_wp) else $error("protect pin lag");
property p_err_done;
   cmd_error |-> cmd_done;
endproperty
a_err_done: assert property (p_err_done) else $error("lone error");
property p_done_one;
   cmd_done |=> !cmd_done;
endproperty
a_done_one: assert property (p_done_one) else $error("done too long");
property p_busy_no_done;
   !ready_busy_out |-> !cmd_done;
endproperty
a_busy_no_done: assert property (p_busy_no_done) else $error("done busy");
endmodule // nfhc_host_asserts
bind nfhc_host nfhc_host_asserts chk_u (
   .mclk(mclk), .rst(rst), .cmd_done(cmd_done), .cmd_error(cmd_error),
   .wr_protect_off(wr_protect_off), .nand_ce_n(nand_ce_n),
   .nand_cle(nand_cle), .nand_ale(nand_ale), .nand_we_n(nand_we_n),
   .read_strobe_low(read_strobe_low), .nand_wp_n(nand_wp_n),
   .nand_io_out(nand_io_out), .nand_io_oe(nand_io_oe),
   .ready_busy_out(ready_busy_out)
);

// *** test/nfhc_host_tb.sv ***
// self-checking bench: host sequencer against a behavioural nand device
`timescale 1ns/1ps
module nfhc_host_tb;
reg mclk, rst, cmd_valid, wr_protect_off, wdata_valid, fail0, fail1, acc;
reg [2:0] cmd_op;
reg [16:0] cmd_row_a, cmd_row_b;
reg [11:0] cmd_col, cmd_len, cmd_col2, cmd_len2;
reg [7:0] wdata;
wire cmd_ready, cmd_done, cmd_error, wdata_ready, nand_ce_n, nand_cle;
wire nand_ale, nand_we_n, read_strobe_low, nand_wp_n, nand_io_oe;
wire ready_busy_out;
wire [7:0] status_q, nand_io_out, nand_io_in;
reg [31:0] lfsr;
reg [8:0] expq[$];
reg [7:0] sent[$];
reg [5:0] pg;
integer n_errors, compares, need, n_done, k, c0, nc;
nfhc_host #(.BUSY_WAIT_MAX(32'd2000)) dut_u (.*);
nfhc_dev_model #(.BUSY_NS(4000)) dev_u (.*);
////////////////////////////////////////////////////////////////////////////
function [31:0] nxt(input [31:0] v);
   nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
endfunction
task chk(input [8:0] got, input [8:0] exp);
   begin
      compares = compares + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
      end
   end
endtask
task summarize;
   begin
      $display("n_errors=%0d compares=%0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   end
endtask
// refused requests consume no bytes, so nothing is fed for them
task run(input [2:0] op, input [16:0] ra, input [16:0] rb, input [11:0] c,
   input [11:0] l, input [11:0] c2, input [11:0] l2, input [8:0] ex);
   begin
      expq.push_back(ex);
      sent.delete();
      need = ex[8] ? 0 : l + l2;
      c0 = n_done;
      {cmd_op, cmd_row_a, cmd_row_b, cmd_col, cmd_len, cmd_col2, cmd_len2} =
         {op, ra, rb, c, l, c2, l2};
      cmd_valid = 1'b1;
      @(posedge mclk);
      while (cmd_ready !== 1'b1) @(posedge mclk);
      @(negedge mclk);
      cmd_valid = 1'b0;
      for (k = 0; n_done == c0 && k < 20000; k = k + 1) @(negedge mclk);
      chk(n_done != c0, 9'h001);
   end
endtask
initial begin
   mclk = 1'b0;
   forever #10 mclk = ~mclk;
end
always @(posedge mclk) begin
   acc <= wdata_valid && wdata_ready;
   if (cmd_done === 1'b1) begin
      n_done = n_done + 1;
      chk({cmd_error, status_q}, expq.size() ? expq.pop_front() : 9'h1ff);
   end
end
always @(negedge mclk) if (acc || !wdata_valid) begin
   lfsr = nxt(lfsr);
   wdata_valid = need > 0 && lfsr[2:0] != 3'h0;
   if (wdata_valid) begin
      wdata = lfsr[15:8];
      sent.push_back(wdata);
      need = need - 1;
   end
end
initial begin
   #1500000;
   n_errors = n_errors + 1;
   summarize;
end
initial begin
   {rst, cmd_valid, wdata_valid, fail0, fail1, acc, wr_protect_off} = 7'h41;
   {cmd_op, cmd_row_a, cmd_row_b, cmd_col, cmd_len, cmd_col2, cmd_len2} = 0;
   {wdata, need, n_done, n_errors, compares} = 0;
   lfsr = 32'h0f69;
   repeat (12) @(posedge mclk);
   @(negedge mclk);
   rst = 1'b0;
   repeat (2) @(negedge mclk);
   pg = lfsr[5:0];
   run(0, {11'h124, pg}, 0, 12'h000, 3, 12'h800, 2, 9'h0e0);
   chk(dev_u.mem[0], sent[0]);
   chk(dev_u.mem[2], sent[2]);
   chk(dev_u.mem[12'h801], sent[4]);
   fail1 = 1'b1;
   run(1, {11'h0b3, pg}, {11'h010, pg}, 0, 0, 0, 0, 9'h1e5);
   fail1 = 1'b0;
   run(2, {11'h3ff, 6'h00}, 0, 0, 0, 0, 0, 9'h0e0);
   fail0 = 1'b1;
   nc = dev_u.n_cmd;
   run(3, {11'h2a0, pg}, {11'h7ff, pg}, 0, 0, 0, 0, 9'h1e3);
   chk(dev_u.n_cmd - nc == 4, 9'h001);
   fail0 = 1'b0;
   run(4, {11'h2a0, pg}, 0, 0, 0, 0, 0, 9'h0e3);
   run(5, {11'h2a0, pg}, {11'h0a2, ~pg}, 12'h010, 1, 12'h020, 1, 9'h0e0);
   chk(dev_u.mem[12'h020], sent[1]);
   nc = dev_u.n_cmd;
   run(5, {11'h2a0, pg}, {11'h0a3, pg}, 0, 1, 0, 0, 9'h1e0);
   run(0, {11'h124, pg}, 0, 12'h840, 1, 0, 0, 9'h1e0);
   run(1, {11'h124, pg}, {11'h126, pg}, 0, 0, 0, 0, 9'h1e0);
   run(1, {11'h124, pg}, {11'h127, ~pg}, 0, 0, 0, 0, 9'h1e0);
   chk(dev_u.n_cmd == nc, 9'h001);
   wr_protect_off = 1'b0;
   repeat (4) @(negedge mclk);
   run(0, {11'h124, pg}, 0, 0, 1, 0, 0, 9'h060);
   wr_protect_off = 1'b1;
   repeat (4) @(negedge mclk);
   run(7, 0, 0, 0, 0, 0, 0, 9'h060);
   run(6, 0, 0, 0, 0, 0, 0, 9'h0e0);
   chk(dev_u.n_bad == 0, 9'h001);
   summarize;
end
endmodule // nfhc_host_tb
